// [watchdog_regs.svh]
// Register offsets, field positions and reset values of the watchdog downcounter
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define WDT_ADDR_W 12
`define WDT_OFS_UPPER 12'h000
`define WDT_OFS_HIGH 12'h004
`define WDT_OFS_LOW 12'h008
`define WDT_OFS_CTRL 12'h00c
`define WDT_OFS_STATUS 12'h010
`define WDT_OFS_COUNT 12'h014

`define WDT_CTRL_MODE_BIT 0
`define WDT_CTRL_REFRESH_BIT 1
`define WDT_STAT_ON_BIT 0
`define WDT_STAT_IRQ_BIT 1
`define WDT_STAT_EXPIRED_BIT 2

`define WDT_RELOAD_BYTE_RST 8'hff
`define WDT_REFRESH_FLOOR 24'h000002
`define WDT_COUNT_ONE 24'h000001

`endif

// [wdt_pkg.sv]
// Types shared by the watchdog downcounter files
package wdt_pkg;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b001,
    ST_ON      = 3'b010,
    ST_EXPIRED = 3'b100
  } wdt_state_type;

endpackage

// [wdt_sync.sv]
// Two-flop synchroniser for levels arriving from outside the pclk domain
`timescale 1ns/100ps
module wdt_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

// [watchdog_downcounter.sv]
// 24-bit reloadable watchdog downcounter with APB register access
//
// Overview of operation
// R1: On reaching terminal count the watchdog either requests a device reset or an interrupt.
// R2: The count advances on the dedicated RC oscillator, not on the system clock.
// R3: The watchdog is only on or off, and once on it counts down and never returns to off; the code adds an expired state that holds the count at zero.
// R4: It is enabled by the refresh command or by the always-on option bit.
// R5: With the always-on option bit set it starts counting right after reset.
// R6: The 24-bit reload value is upper, high and low byte concatenated, upper first.
// R7: One count per RC oscillator period, so at 10 kHz the period in ms is reload over ten.
// R8: Once the count has reached 000002H further refreshes are ignored.
// R9: Software never programs a reload value below 000004H.
// R10: An accepted refresh loads the current reload value into the counter.
// R11: Oscillator and option levels pass synchronisers so no count event is lost or doubled.
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module watchdog_downcounter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and nonvolatile option
  input wire logic rc_osc_clk,
  input wire logic always_on_option_bit,
  // Time-out responses
  output logic wdt_reset_req,
  output logic wdt_irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] reload_upper_byte_reg;
  logic [7:0] reload_high_byte_reg;
  logic [7:0] reload_low_byte_reg;
  logic mode_irq_reg;
  logic [23:0] count_reg;
  logic [23:0] count_next;
  wdt_pkg::wdt_state_type state_reg;
  wdt_pkg::wdt_state_type state_next;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic rc_prev_reg;
  logic [1:0] sync_level;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised oscillator and option levels

  // RC clock is sampled as data; it must run well below half of pclk
  wdt_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({always_on_option_bit, rc_osc_clk}),
    .sync_out(sync_level)
  ); // see R11

  wire rc_level = sync_level[0];
  wire ao_level = sync_level[1];
  wire tick = rc_level & ~rc_prev_reg; // see R2 see R7

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire access = psel & penable;
  wire wr_en = access & pwrite & pready_reg;
  wire hit_upper = (paddr == `WDT_OFS_UPPER);
  wire hit_high = (paddr == `WDT_OFS_HIGH);
  wire hit_low = (paddr == `WDT_OFS_LOW);
  wire hit_ctrl = (paddr == `WDT_OFS_CTRL);
  wire hit_status = (paddr == `WDT_OFS_STATUS);
  wire hit_count = (paddr == `WDT_OFS_COUNT);
  wire mapped = hit_upper | hit_high | hit_low | hit_ctrl | hit_status | hit_count;
  wire wr_ok = wr_en & mapped;

  wire refresh_pulse = wr_ok & hit_ctrl & pwdata[`WDT_CTRL_REFRESH_BIT];
  wire irq_clear = wr_ok & hit_status & pwdata[`WDT_STAT_IRQ_BIT];

  wire is_off = (state_reg == wdt_pkg::ST_OFF);
  wire is_on = (state_reg == wdt_pkg::ST_ON);
  wire is_expired = (state_reg == wdt_pkg::ST_EXPIRED);

  wire [31:0] status_word = {29'h0000000, is_expired, irq_reg, is_on};
  wire [31:0] ctrl_word = {31'h00000000, mode_irq_reg};
  wire [31:0] rd_data =
    hit_upper ? {24'h000000, reload_upper_byte_reg} :
    hit_high ? {24'h000000, reload_high_byte_reg} :
    hit_low ? {24'h000000, reload_low_byte_reg} :
    hit_ctrl ? ctrl_word :
    hit_status ? status_word :
    hit_count ? {8'h00, count_reg} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Counter control

  wire [23:0] reload_value = {reload_upper_byte_reg, reload_high_byte_reg,
                              reload_low_byte_reg}; // see R6
  // Close to expiry a late refresh could race the time-out, so it is dropped
  wire refresh_ok = is_on & refresh_pulse & (count_reg > `WDT_REFRESH_FLOOR); // see R8
  // Reaching zero is terminal; a zero reload expires on the next tick
  wire expire = is_on & tick & (count_reg <= `WDT_COUNT_ONE); // see R1
  wire enable_now = is_off & (refresh_pulse | ao_level); // see R4 see R5

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      wdt_pkg::ST_OFF: begin
        if (enable_now) begin
          state_next = wdt_pkg::ST_ON;
          count_next = reload_value; // see R4
        end
      end
      wdt_pkg::ST_ON: begin
        if (refresh_ok) begin
          count_next = reload_value; // see R10
        end else if (expire) begin
          if (mode_irq_reg) begin
            count_next = reload_value;
          end else begin
            state_next = wdt_pkg::ST_EXPIRED;
            count_next = 24'h000000;
          end
        end else if (tick) begin
          count_next = count_reg - 24'h000001; // see R3
        end
      end
      wdt_pkg::ST_EXPIRED: begin
        count_next = 24'h000000;
      end
      default: begin
        state_next = wdt_pkg::ST_OFF;
        count_next = 24'h000000;
      end
    endcase
  end

  // Interrupt request set wins over a simultaneous clear
  wire irq_next = (expire & mode_irq_reg) | (irq_reg & ~irq_clear); // see R1

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= wdt_pkg::ST_OFF;
      count_reg <= 24'h000000;
      rc_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
      wdt_reset_req <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      rc_prev_reg <= rc_level;
      irq_reg <= irq_next;
      wdt_reset_req <= (state_next == wdt_pkg::ST_EXPIRED); // see R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_upper_byte_reg <= `WDT_RELOAD_BYTE_RST;
      reload_high_byte_reg <= `WDT_RELOAD_BYTE_RST;
      reload_low_byte_reg <= `WDT_RELOAD_BYTE_RST;
      mode_irq_reg <= 1'b0;
    end else begin
      if (wr_ok & hit_upper) reload_upper_byte_reg <= pwdata[7:0];
      if (wr_ok & hit_high) reload_high_byte_reg <= pwdata[7:0];
      if (wr_ok & hit_low) reload_low_byte_reg <= pwdata[7:0];
      if (wr_ok & hit_ctrl) mode_irq_reg <= pwdata[`WDT_CTRL_MODE_BIT];
    end
  end

  // One wait state; read data and error are captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~mapped;
      if (access & ~pready_reg & ~pwrite) prdata_reg <= mapped ? rd_data : 32'h00000000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign wdt_irq_req = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_refresh_reload: assert property ( // see R10
    refresh_ok |=> count_reg == $past(reload_value))
    else $error("Accepted refresh did not load reload value");

  chk_refresh_ignored: assert property ( // see R8
    (is_on && refresh_pulse && count_reg <= `WDT_REFRESH_FLOOR && !tick)
      |=> count_reg == $past(count_reg))
    else $error("Refresh near terminal count was not ignored");

  chk_count_down: assert property ( // see R3
    (is_on && tick && !refresh_pulse && count_reg > `WDT_COUNT_ONE)
      |=> count_reg == $past(count_reg) - 24'h000001)
    else $error("Counter did not step down on oscillator tick");

  chk_hold_no_tick: assert property ( // see R2
    (is_on && !tick && !refresh_pulse) |=> count_reg == $past(count_reg))
    else $error("Counter moved without an oscillator tick");

  chk_enable_refresh: assert property ( // see R4
    (is_off && refresh_pulse) |=> is_on ##0 count_reg == $past(reload_value))
    else $error("Refresh did not enable the watchdog");

  chk_always_on: assert property ( // see R5
    (is_off && ao_level) |=> is_on)
    else $error("Always-on option did not start the watchdog");

  chk_reset_resp: assert property ( // see R1
    (expire && !mode_irq_reg) |=> wdt_reset_req [*4])
    else $error("Reset response not held after expiry");

  chk_irq_resp: assert property ( // see R1
    (expire && mode_irq_reg) |=> wdt_irq_req && !wdt_reset_req)
    else $error("Interrupt response missing after expiry");

  chk_never_off: assert property ( // see R3
    !is_off |=> !is_off)
    else $error("Watchdog turned off after being enabled");

  // One oscillator edge may move the count by one step only, never two
  chk_tick_single: assert property ( // see R11
    (is_on && tick && !refresh_pulse && count_reg > `WDT_COUNT_ONE) ##1 !refresh_pulse
      |=> count_reg == $past(count_reg, 2) - 24'h000001)
    else $error("Oscillator edge counted twice");

  chk_apb_answer: assert property (
    (access && !pready_reg) |=> pready_reg ##1 !pready_reg)
    else $error("APB answer not one cycle after access");

  cov_refresh: cover property (refresh_ok);
  cov_ignored: cover property (is_on && refresh_pulse && !refresh_ok);
  cov_irq_expiry: cover property (expire && mode_irq_reg);
  cov_reset_expiry: cover property (expire && !mode_irq_reg);

endmodule

// [watchdog_downcounter_test.sv]
// Self-checking testbench for the watchdog downcounter
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module watchdog_downcounter_test;
  // Clock and reset
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  // APB master side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Oscillator, option and responses
  logic rc_osc_clk = 1'b0;
  logic always_on_option_bit = 1'b0;
  logic wdt_reset_req;
  logic wdt_irq_req;
  int errors = 0;
  int n_tests = 0;
  logic [31:0] rdata;
  logic rerr;

  watchdog_downcounter watchdog_downcounter_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_clk(rc_osc_clk), .always_on_option_bit(always_on_option_bit),
    .wdt_reset_req(wdt_reset_req), .wdt_irq_req(wdt_irq_req)
  );

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic ao);
    presetn <= 1'b0;
    always_on_option_bit <= ao;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // Holds the request until pready is seen; an extra idle edge avoids back-to-back redrives
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("CHECK FAILED at %0t: no pready", $time);
      test_done();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdata, exp);
  endtask

  // n oscillator periods of eight pclk cycles each, slow enough for the two-flop sampler
  task automatic tick(input int n);
    repeat (n) begin
      rc_osc_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      rc_osc_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  task automatic set_reload(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
    apb(1'b1, `WDT_OFS_UPPER, {24'h000000, u});
    apb(1'b1, `WDT_OFS_HIGH, {24'h000000, h});
    apb(1'b1, `WDT_OFS_LOW, {24'h000000, l});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_mode;
    do_reset(1'b0);
    rd_chk(`WDT_OFS_UPPER, 32'h000000ff);
    rd_chk(`WDT_OFS_STATUS, 32'h00000000);
    tick(2);
    rd_chk(`WDT_OFS_COUNT, 32'h00000000);
    apb(1'b0, 12'h0f0, 32'h00000000);
    chk({31'h0, rerr}, 32'h00000001);
    set_reload(8'h12, 8'h34, 8'h56);
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000002);
    rd_chk(`WDT_OFS_COUNT, 32'h00123456);
    rd_chk(`WDT_OFS_STATUS, 32'h00000001);
    set_reload(8'h00, 8'h00, 8'h05);
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000002);
    rd_chk(`WDT_OFS_COUNT, 32'h00000005);
    tick(1);
    rd_chk(`WDT_OFS_COUNT, 32'h00000004);
    tick(2);
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000002);
    rd_chk(`WDT_OFS_COUNT, 32'h00000002);
    tick(1);
    chk({31'h0, wdt_reset_req}, 32'h00000000);
    tick(1);
    chk({31'h0, wdt_reset_req}, 32'h00000001);
    chk({31'h0, wdt_irq_req}, 32'h00000000);
    rd_chk(`WDT_OFS_STATUS, 32'h00000004);
  endtask

  task automatic test_irq_mode;
    do_reset(1'b0);
    chk({31'h0, wdt_reset_req}, 32'h00000000);
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000001);
    set_reload(8'h00, 8'h00, 8'h04);
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000003);
    rd_chk(`WDT_OFS_CTRL, 32'h00000001);
    tick(1);
    // Count 3 is just above the floor, so this refresh must still land
    apb(1'b1, `WDT_OFS_CTRL, 32'h00000003);
    rd_chk(`WDT_OFS_COUNT, 32'h00000004);
    tick(3);
    chk({31'h0, wdt_irq_req}, 32'h00000000);
    tick(1);
    chk({31'h0, wdt_irq_req}, 32'h00000001);
    chk({31'h0, wdt_reset_req}, 32'h00000000);
    rd_chk(`WDT_OFS_STATUS, 32'h00000003);
    rd_chk(`WDT_OFS_COUNT, 32'h00000004);
    apb(1'b1, `WDT_OFS_STATUS, 32'h00000002);
    chk({31'h0, wdt_irq_req}, 32'h00000000);
  endtask

  task automatic test_always_on;
    do_reset(1'b1);
    repeat (4) @(posedge pclk);
    rd_chk(`WDT_OFS_STATUS, 32'h00000001);
    rd_chk(`WDT_OFS_COUNT, 32'h00ffffff);
    tick(1);
    rd_chk(`WDT_OFS_COUNT, 32'h00fffffe);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    test_reset_mode();
    test_irq_mode();
    test_always_on();
    test_done();
  end
endmodule
